// File: logic/uecsc_pkg.sv
`default_nettype none

package uecsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_EP  = 8;
    localparam int NUM_DMA = 7;
    localparam int ADDR_W  = 12;
    localparam int IRQ_EN_W = 13;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [11:0] EP_CTRL_BASE  = 12'h1c0;
    localparam logic [11:0] EP_SET_BASE   = 12'h1f0;
    localparam logic [11:0] EP_CLR_BASE   = 12'h220;
    localparam logic [11:0] EP_STRIDE     = 12'h004;
    localparam logic [11:0] EP_SPAN       = 12'h020;
    localparam logic [11:0] DMA_NEXT_BASE = 12'h310;
    localparam logic [11:0] DMA_STRIDE    = 12'h010;
    localparam logic [11:0] DMA_SPAN      = 12'h070;
    localparam logic [11:0] FEATURE_OFF   = 12'h0f8;

    ////////////////////////////////////////////////////////////////////////////
    // endpoint control word fields
    localparam int BIT_IN_SENT      = 0;
    localparam int BIT_OUT_RCVD     = 1;
    localparam int BIT_SETUP_UNDER  = 2;
    localparam int BIT_NAKOUT_HBERR = 3;
    localparam int BIT_NAKIN_HBFLSH = 4;
    localparam int BIT_OVERFLOW     = 5;
    localparam int BIT_STALL_CRC    = 6;
    localparam int BIT_SHORT_PKT    = 7;
    localparam int BIT_MULTI_PID    = 8;
    localparam int BIT_SINGLE_PID   = 9;
    localparam int BIT_TRANS_FAULT  = 10;
    localparam int BIT_BUSY_BANK    = 12;
    localparam int BIT_BANK_DISCARD = 13;
    localparam int BIT_FIFO_CTRL    = 14;
    localparam int BIT_DMA_PAUSE    = 16;
    localparam int BIT_NYET_DIS     = 17;
    localparam int BIT_TOGGLE_RST   = 18;
    localparam int BIT_STALL_REQ    = 19;

    localparam logic [31:0] SET_MASK   = 32'h000f_37ff;
    localparam logic [31:0] CLR_MASK   = 32'h000b_57ff;
    localparam logic [31:0] STORE_MASK = 32'h000b_77ff;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    localparam logic [31:0] NEXT_DESC_MASK  = 32'hffff_fff0;
    localparam logic [31:0] NEXT_DESC_RESET = 32'h0000_0000;

    localparam int FEAT_HB_ISO_BIT = 0;
    localparam int FEAT_EP_LSB     = 4;
    localparam int FEAT_DMA_LSB    = 8;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic setup_rcvd;
        logic kill_done;
        logic bank_ready;
    } uecsc_ep_evt_t;

    typedef struct packed {
        logic [IRQ_EN_W-1:0] irq_en;
        logic                hb_iso_in_flush_irq_en;
        logic                hb_iso_in_fault_irq_en;
        logic                bank_discard;
        logic                fifo_ctrl;
        logic                dma_pause;
        logic                nyet_disable;
        logic                stall_req;
        logic                toggle_reset;
    } uecsc_ep_ctrl_t;

    typedef struct packed {
        logic        load;
        logic [31:0] addr;
    } uecsc_desc_load_t;

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic in_window(input logic [11:0] adr,
                                       input logic [11:0] base,
                                       input logic [11:0] span,
                                       input logic [11:0] stride);
        logic [11:0] d;
        d = adr - base;
        in_window = (adr >= base) && (d < span) && ((d & (stride - 12'h001)) == 12'h000);
    endfunction

endpackage

`default_nettype wire

// File: logic/uecsc_ep_reg.sv
`timescale 1ns/1ps
`default_nettype none

module uecsc_ep_reg
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [31:0]               set_i,
    input  wire logic [31:0]               clr_i,
    input  wire uecsc_pkg::uecsc_ep_evt_t  evt_i,
    output logic      [31:0]               ctrl_o
);
    import uecsc_pkg::*;

    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    wire  [31:0] hw_clr;
    wire  [31:0] hw_set;

    ////////////////////////////////////////////////////////////////////////////
    // hardware-side effects
    assign hw_clr = ({31'h0, evt_i.setup_rcvd} << BIT_STALL_REQ)
                  | ({31'h0, evt_i.kill_done} << BIT_BANK_DISCARD);
    assign hw_set = {31'h0, evt_i.bank_ready} << BIT_FIFO_CTRL;

    // software set beats a hardware clear; a hardware set beats a software clear
    assign ctrl_nxt = ((ctrl_r & ~(clr_i | hw_clr)) | set_i | hw_set) & STORE_MASK;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_r <= CTRL_RESET;
        else
            ctrl_r <= ctrl_nxt;
    end

    assign ctrl_o = ctrl_r;

endmodule

`default_nettype wire

// File: logic/uecsc_dma_next.sv
`timescale 1ns/1ps
`default_nettype none

module uecsc_dma_next
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wr_i,
    input  wire logic [31:0]                 wdata_i,
    input  wire logic [31:0]                 wmask_i,
    input  wire uecsc_pkg::uecsc_desc_load_t desc_i,
    output logic      [31:0]                 next_o
);
    import uecsc_pkg::*;

    logic [31:0] next_r;
    logic [31:0] next_nxt;

    // software write wins over a descriptor load in the same cycle
    assign next_nxt = wr_i        ? ((next_r & ~wmask_i) | (wdata_i & wmask_i)) & NEXT_DESC_MASK
                    : desc_i.load ? desc_i.addr & NEXT_DESC_MASK
                    : next_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            next_r <= NEXT_DESC_RESET;
        else
            next_r <= next_nxt;
    end

    assign next_o = next_r;

endmodule

`default_nettype wire

// File: logic/uecsc_top.sv
// Summary of operation
// - Per endpoint, a write-only set alias; ones written set matching control bits.
// - Per endpoint, a write-only clear alias; ones written clear matching control bits.
// - Zeros written to either alias change nothing.
// - Bit 12 busy-bank-count interrupt enable, set and cleared via aliases.
// - Bit 10 transaction fault interrupt enable, set and cleared via aliases.
// - Bit 9 single data-PID interrupt enable, set and cleared via aliases.
// - Bit 8 multiple data-PID interrupt enable, set and cleared via aliases.
// - Bit 7 short packet interrupt enable, set and cleared via aliases.
// - Bit 6 is the stall-sent interrupt enable via aliases.
// - Bit 6 also enables the CRC fault interrupt, same set and clear.
// - Bit 5 overflow interrupt enable, set and cleared via aliases.
// - Bit 4 is NAKed IN enable and high-bandwidth iso flush enable.
// - High-bandwidth iso enables exist only when the feature register reports support.
// - Bit 3 is NAKed OUT enable and high-bandwidth iso IN fault enable.
// - Bit 2 is the SETUP received interrupt enable via aliases.
// - Bit 2 also enables the underflow interrupt, same set and clear.
// - Bit 1 OUT received interrupt enable, set and cleared via aliases.
// - Bit 0 IN sent interrupt enable, set and cleared via aliases.
// - Per DMA channel next-descriptor register, bits 31:4 address, resets zero.
// - Next-descriptor updated by software write or by descriptor loading.
// - Bank discard set by alias, cleared by hardware when discard completes.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module uecsc_top
#(
    parameter logic HB_ISO_PRESENT = 1'b1
)
(
    input  wire logic                                              clk_i,
    input  wire logic                                              rst_i,
    input  wire logic                                              wb_cyc_i,
    input  wire logic                                              wb_stb_i,
    input  wire logic                                              wb_we_i,
    input  wire logic [uecsc_pkg::ADDR_W-1:0]                      wb_adr_i,
    input  wire logic [3:0]                                        wb_sel_i,
    input  wire logic [31:0]                                       wb_dat_i,
    output logic      [31:0]                                       wb_dat_o,
    output logic                                                   wb_ack_o,
    input  wire uecsc_pkg::uecsc_ep_evt_t    [uecsc_pkg::NUM_EP-1:0]  ep_evt_i,
    output var  uecsc_pkg::uecsc_ep_ctrl_t   [uecsc_pkg::NUM_EP-1:0]  ep_ctrl_o,
    input  wire uecsc_pkg::uecsc_desc_load_t [uecsc_pkg::NUM_DMA-1:0] desc_load_i,
    output logic [uecsc_pkg::NUM_DMA-1:0][31:0]                    next_desc_o
);
    import uecsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake

    logic        ack_r;
    logic [31:0] dat_r;
    logic [NUM_EP-1:0] toggle_r;

    wire req     = wb_cyc_i & wb_stb_i;
    wire first   = req & ~ack_r;
    // a write lands only at the edge where ack is seen high
    wire commit  = req & wb_we_i & ack_r;

    wire [31:0] lanes = lane_mask(wb_sel_i);
    wire [31:0] wdata = wb_dat_i & lanes;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    wire hit_set  = in_window(wb_adr_i, EP_SET_BASE, EP_SPAN, EP_STRIDE);
    wire hit_clr  = in_window(wb_adr_i, EP_CLR_BASE, EP_SPAN, EP_STRIDE);
    wire hit_ctrl = in_window(wb_adr_i, EP_CTRL_BASE, EP_SPAN, EP_STRIDE);
    wire hit_dma  = in_window(wb_adr_i, DMA_NEXT_BASE, DMA_SPAN, DMA_STRIDE);
    wire hit_feat = (wb_adr_i == FEATURE_OFF);

    wire [11:0] off_set  = wb_adr_i - EP_SET_BASE;
    wire [11:0] off_clr  = wb_adr_i - EP_CLR_BASE;
    wire [11:0] off_ctrl = wb_adr_i - EP_CTRL_BASE;
    wire [11:0] off_dma  = wb_adr_i - DMA_NEXT_BASE;

    wire [2:0] idx_set  = off_set[4:2];
    wire [2:0] idx_clr  = off_clr[4:2];
    wire [2:0] idx_ctrl = off_ctrl[4:2];
    wire [2:0] idx_dma  = off_dma[6:4];

    // unused alias positions are masked off before they reach the register
    wire [31:0] set_word = wdata & SET_MASK;
    wire [31:0] clr_word = wdata & CLR_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // endpoint control registers

    logic [NUM_EP-1:0][31:0] ep_word;
    logic [NUM_EP-1:0][31:0] ep_set;
    logic [NUM_EP-1:0][31:0] ep_clr;
    logic [NUM_EP-1:0]       ep_toggle_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1)
        begin : g_ep
            wire set_sel = commit & hit_set & (idx_set == 3'(g));
            wire clr_sel = commit & hit_clr & (idx_clr == 3'(g));

            assign ep_set[g] = set_sel ? set_word : 32'h0000_0000;
            assign ep_clr[g] = clr_sel ? clr_word : 32'h0000_0000;

            // toggle reset is an action, never stored: one pulse per write
            assign ep_toggle_hit[g] = ep_set[g][BIT_TOGGLE_RST];

            uecsc_ep_reg u_ep
            (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .set_i  (ep_set[g]),
                .clr_i  (ep_clr[g]),
                .evt_i  (ep_evt_i[g]),
                .ctrl_o (ep_word[g])
            );

            assign ep_ctrl_o[g].irq_en = {
                ep_word[g][BIT_BUSY_BANK],
                1'b0,
                ep_word[g][BIT_TRANS_FAULT],
                ep_word[g][BIT_SINGLE_PID],
                ep_word[g][BIT_MULTI_PID],
                ep_word[g][BIT_SHORT_PKT],
                ep_word[g][BIT_STALL_CRC],
                ep_word[g][BIT_OVERFLOW],
                ep_word[g][BIT_NAKIN_HBFLSH],
                ep_word[g][BIT_NAKOUT_HBERR],
                ep_word[g][BIT_SETUP_UNDER],
                ep_word[g][BIT_OUT_RCVD],
                ep_word[g][BIT_IN_SENT]
            };

            // the iso roles only exist when the feature is built in
            assign ep_ctrl_o[g].hb_iso_in_flush_irq_en =
                ep_word[g][BIT_NAKIN_HBFLSH] & HB_ISO_PRESENT;
            assign ep_ctrl_o[g].hb_iso_in_fault_irq_en =
                ep_word[g][BIT_NAKOUT_HBERR] & HB_ISO_PRESENT;

            assign ep_ctrl_o[g].bank_discard = ep_word[g][BIT_BANK_DISCARD];
            assign ep_ctrl_o[g].fifo_ctrl    = ep_word[g][BIT_FIFO_CTRL];
            assign ep_ctrl_o[g].dma_pause    = ep_word[g][BIT_DMA_PAUSE];
            assign ep_ctrl_o[g].nyet_disable = ep_word[g][BIT_NYET_DIS];
            assign ep_ctrl_o[g].stall_req    = ep_word[g][BIT_STALL_REQ];
            assign ep_ctrl_o[g].toggle_reset = toggle_r[g];
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            toggle_r <= '0;
        else
            toggle_r <= ep_toggle_hit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // dma next-descriptor registers

    generate
        for (g = 0; g < NUM_DMA; g = g + 1)
        begin : g_dma
            wire wr_sel = commit & hit_dma & (idx_dma == 3'(g));

            uecsc_dma_next u_dma
            (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .wr_i    (wr_sel),
                .wdata_i (wb_dat_i),
                .wmask_i (lanes),
                .desc_i  (desc_load_i[g]),
                .next_o  (next_desc_o[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read-back

    wire [31:0] feature_word = ({31'h0, HB_ISO_PRESENT} << FEAT_HB_ISO_BIT)
                             | (32'(NUM_EP) << FEAT_EP_LSB)
                             | (32'(NUM_DMA) << FEAT_DMA_LSB);

    wire [31:0] rd_ctrl = ep_word[idx_ctrl];
    wire [31:0] rd_dma  = (idx_dma < 3'(NUM_DMA)) ? next_desc_o[idx_dma] : 32'h0000_0000;

    // aliases and holes answer with zero, so software never sees stale data
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl
                        : hit_dma  ? rd_dma
                        : hit_feat ? feature_word
                        : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= first;
            if (first & ~wb_we_i)
                dat_r <= rd_data;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule

`default_nettype wire

// File: verification/uecsc_props.sv
`timescale 1ns/1ps
`default_nettype none

module uecsc_props
#(
    parameter logic HB_ISO_PRESENT = 1'b1
)
(
    input wire logic                                               clk_i,
    input wire logic                                               rst_i,
    input wire logic                                               wb_cyc_i,
    input wire logic                                               wb_stb_i,
    input wire logic                                               wb_we_i,
    input wire logic [uecsc_pkg::ADDR_W-1:0]                       wb_adr_i,
    input wire logic [3:0]                                         wb_sel_i,
    input wire logic [31:0]                                        wb_dat_i,
    input wire logic [31:0]                                        wb_dat_o,
    input wire logic                                               wb_ack_o,
    input wire uecsc_pkg::uecsc_ep_evt_t    [uecsc_pkg::NUM_EP-1:0]  ep_evt_i,
    input wire uecsc_pkg::uecsc_ep_ctrl_t   [uecsc_pkg::NUM_EP-1:0]  ep_ctrl_o,
    input wire uecsc_pkg::uecsc_desc_load_t [uecsc_pkg::NUM_DMA-1:0] desc_load_i,
    input wire logic [uecsc_pkg::NUM_DMA-1:0][31:0]                next_desc_o
);
    import uecsc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    wire logic [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wbits   = wb_dat_i & wmask;
    wire logic        req     = wb_cyc_i && wb_stb_i;
    wire logic        wcommit = req && wb_we_i && wb_ack_o;
    wire logic [11:0] set_off = wb_adr_i - 12'h1f0;
    wire logic        set_hit = wb_adr_i >= 12'h1f0 && wb_adr_i < 12'h210 && wb_adr_i[1:0] == 2'h0;
    wire logic        clr_hit = wb_adr_i >= 12'h220 && wb_adr_i < 12'h240 && wb_adr_i[1:0] == 2'h0;
    logic             v_set_r;
    logic             v_clr_r;
    logic [2:0]       ep_r;
    logic [12:0]      m_r;
    logic             lo_any;
    // endpoint index kept after commit so later cycles still look at it
    always_ff @(posedge clk_i)
    begin
        v_set_r <= !rst_i && wcommit && set_hit;
        v_clr_r <= !rst_i && wcommit && clr_hit;
        if (wcommit)
        begin
            ep_r <= set_hit ? set_off[4:2] : wb_adr_i[4:2];
            m_r  <= wbits[12:0] & 13'h17ff;
        end
    end
    always_comb
    begin
        lo_any = 1'b0;
        for (int g = 0; g < NUM_DMA; g++)
            lo_any = lo_any | (|next_desc_o[g][3:0]);
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_set_commit;
        wcommit && set_hit;
    endsequence
    sequence s_toggle_pulse;
        ep_ctrl_o[ep_r].toggle_reset ##1 !ep_ctrl_o[ep_r].toggle_reset;
    endsequence
    property p_ack_latency;
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_set_bits;
        v_set_r |-> (ep_ctrl_o[ep_r].irq_en & m_r) == m_r;
    endproperty
    property p_clr_bits;
        v_clr_r |-> (ep_ctrl_o[ep_r].irq_en & m_r) == 13'h0000;
    endproperty
    property p_zero_keep;
        wcommit && (set_hit || clr_hit) && wbits == 32'h0 |=> $stable(ep_ctrl_o);
    endproperty
    property p_alias_read;
        req && !wb_we_i && !wb_ack_o && (set_hit || clr_hit) |=> wb_dat_o == 32'h0;
    endproperty
    property p_toggle;
        s_set_commit ##0 wbits[18] |=> s_toggle_pulse;
    endproperty
    property p_kill;
        ep_evt_i[0].kill_done && !wb_ack_o |=> !ep_ctrl_o[0].bank_discard;
    endproperty
    property p_desc_load;
        desc_load_i[0].load && !wb_ack_o |=> next_desc_o[0] == ($past(desc_load_i[0].addr) & 32'hffff_fff0);
    endproperty
    property p_desc_low;
        !lo_any;
    endproperty
    property p_hb_gate;
        ep_ctrl_o[0].hb_iso_in_flush_irq_en == (ep_ctrl_o[0].irq_en[4] && HB_ISO_PRESENT);
    endproperty
    a_ack_latency: assert property (p_ack_latency) else $error("ack timing wrong");
    a_set_bits: assert property (p_set_bits) else $error("set alias bit not set");
    a_clr_bits: assert property (p_clr_bits) else $error("clear alias bit not cleared");
    a_zero_keep: assert property (p_zero_keep) else $error("zero write changed control");
    a_alias_read: assert property (p_alias_read) else $error("alias read not zero");
    a_toggle: assert property (p_toggle) else $error("toggle pulse wrong");
    a_kill: assert property (p_kill) else $error("discard not cleared");
    a_desc_load: assert property (p_desc_load) else $error("descriptor load wrong");
    a_desc_low: assert property (p_desc_low) else $error("descriptor low bits set");
    a_hb_gate: assert property (p_hb_gate) else $error("iso enable gating wrong");
endmodule

`default_nettype wire

// File: verification/uecsc_evt_model.sv
`timescale 1ns/1ps
`default_nettype none

module uecsc_evt_model
(
    input  wire logic                                             clk_i,
    input  wire logic                                             rst_i,
    input  wire logic [3:0]                                       dly_i,
    input  wire uecsc_pkg::uecsc_ep_ctrl_t [uecsc_pkg::NUM_EP-1:0] ctrl_i,
    input  wire uecsc_pkg::uecsc_ep_evt_t  [uecsc_pkg::NUM_EP-1:0] tb_evt_i,
    output wire uecsc_pkg::uecsc_ep_evt_t  [uecsc_pkg::NUM_EP-1:0] evt_o
);
    import uecsc_pkg::*;
    logic [3:0] cnt_r  [NUM_EP];
    logic       kill_r [NUM_EP];
    ////////////////////////////////////////////////////////////////////////////
    for (genvar e = 0; e < NUM_EP; e++)
    begin : g_ep
        // discard finishes dly_i cycles late; one pulse, then the count restarts if the bit is still set
        always_ff @(posedge clk_i)
        begin
            if (rst_i || !ctrl_i[e].bank_discard || kill_r[e])
            begin
                cnt_r[e]  <= 4'h0;
                kill_r[e] <= 1'b0;
            end
            else if (cnt_r[e] == dly_i)
                kill_r[e] <= 1'b1;
            else
                cnt_r[e] <= cnt_r[e] + 4'h1;
        end
        assign evt_o[e] = {tb_evt_i[e].setup_rcvd, kill_r[e], tb_evt_i[e].bank_ready};
    end
endmodule

`default_nettype wire

// File: verification/uecsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uecsc_top_tb;
    import uecsc_pkg::*;
    logic                           clk_i = 1'b0;
    logic                           rst_i = 1'b1;
    logic                           cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0]                    adr = 12'h000;
    logic [3:0]                     sel = 4'h0, dly = 4'h0;
    logic [31:0]                    wdat = 32'h0, rdat, dat_o;
    wire logic                      ack;
    uecsc_ep_evt_t [NUM_EP-1:0]     tb_evt = '0;
    wire uecsc_ep_evt_t [NUM_EP-1:0] evt;
    uecsc_ep_ctrl_t [NUM_EP-1:0]    ctrl;
    uecsc_desc_load_t [NUM_DMA-1:0] dload = '0;
    logic [NUM_DMA-1:0][31:0]       nd;
    int                             n_fail = 0, compares = 0, ticks = 0;

    uecsc_top #(.HB_ISO_PRESENT(1'b1)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ep_evt_i(evt), .ep_ctrl_o(ctrl), .desc_load_i(dload), .next_desc_o(nd));
    uecsc_evt_model model (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly), .ctrl_i(ctrl), .tb_evt_i(tb_evt), .evt_o(evt));
    ////////////////////////////////////////////////////////////////////////////
    initial forever #2 clk_i = ~clk_i;
    // whole run needs about 1300 cycles
    always @(posedge clk_i)
    begin
        ticks <= ticks + 1;
        if (ticks == 30000)
        begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // classic cycle; ack read before the edge's own updates land
    task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (ack !== 1'b1 && t < 50);
        if (ack !== 1'b1)
        begin
            n_fail++;
            final_report();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int n = 0; n < NUM_EP; n++)
        begin
            wb(1'b0, 12'h1c0 + 12'(4 * n), 4'hf, 32'h0);
            chk("ctrl reset", rdat, 32'h0);
        end
        for (int c = 0; c < NUM_DMA; c++)
        begin
            wb(1'b0, 12'h310 + 12'(16 * c), 4'hf, 32'h0);
            chk("desc reset", rdat, 32'h0);
        end
        $display("test reset done");
    endtask
    task automatic t_bits;
        for (int n = 0; n < NUM_EP; n++)
            for (int b = 0; b < 13; b++)
                if (b != 11)
                begin
                    wb(1'b1, 12'h1f0 + 12'(4 * n), 4'hf, 32'h1 << b);
                    chk("hb", 32'({ctrl[n].hb_iso_in_flush_irq_en, ctrl[n].hb_iso_in_fault_irq_en}), 32'({b == 4, b == 3}));
                    wb(1'b0, 12'h1c0 + 12'(4 * n), 4'hf, 32'h0);
                    chk("set bit", rdat, 32'h1 << b);
                    wb(1'b1, 12'h220 + 12'(4 * n), 4'hf, 32'h1 << b);
                    wb(1'b0, 12'h1c0 + 12'(4 * n), 4'hf, 32'h0);
                    chk("clr bit", rdat, 32'h0);
                end
        $display("test bits done");
    endtask
    task automatic t_mask;
        wb(1'b1, 12'h208, 4'hf, 32'hfff0_c800);
        wb(1'b0, 12'h1d8, 4'hf, 32'h0);
        chk("unused", rdat, 32'h0);
        wb(1'b1, 12'h208, 4'hf, 32'h000b_17ff);
        wb(1'b1, 12'h208, 4'hf, 32'h0);
        wb(1'b1, 12'h238, 4'hf, 32'h0);
        wb(1'b0, 12'h1d8, 4'hf, 32'h0);
        chk("zero write", rdat, 32'h000b_17ff);
        wb(1'b0, 12'h208, 4'hf, 32'h0);
        chk("set read", rdat, 32'h0);
        wb(1'b0, 12'h238, 4'hf, 32'h0);
        chk("clr read", rdat, 32'h0);
        wb(1'b1, 12'h238, 4'hf, 32'hffff_ffff);
        wb(1'b1, 12'h208, 4'h1, 32'hffff_ffff);
        wb(1'b1, 12'h238, 4'h2, 32'hffff_ffff);
        wb(1'b0, 12'h1d8, 4'hf, 32'h0);
        chk("lanes", rdat, 32'h0000_00ff);
        wb(1'b1, 12'h238, 4'hf, 32'hffff_ffff);
        $display("test mask done");
    endtask
    task automatic t_toggle_stall;
        wb(1'b1, 12'h1fc, 4'hf, 32'h0004_0000);
        chk("toggle hi", 32'(ctrl[3].toggle_reset), 32'h1);
        @(posedge clk_i);
        chk("toggle lo", 32'(ctrl[3].toggle_reset), 32'h0);
        wb(1'b1, 12'h1f4, 4'hf, 32'h0008_0000);
        tb_evt[1].setup_rcvd <= 1'b1;
        @(posedge clk_i);
        tb_evt[1].setup_rcvd <= 1'b0;
        tb_evt[1].bank_ready <= 1'b1;
        @(posedge clk_i);
        tb_evt[1].bank_ready <= 1'b0;
        chk("stall", 32'(ctrl[1].stall_req), 32'h0);
        wb(1'b0, 12'h1c4, 4'hf, 32'h0);
        chk("fifo", rdat, 32'h0000_4000);
        wb(1'b1, 12'h224, 4'hf, 32'h0000_4000);
        wb(1'b0, 12'h1c4, 4'hf, 32'h0);
        chk("fifo clr", rdat, 32'h0);
        $display("test toggle done");
    endtask
    task automatic t_kill(input logic [3:0] d);
        int t;
        t = 0;
        dly <= d;
        wb(1'b1, 12'h1f8, 4'hf, 32'h0000_2000);
        chk("discard", 32'(ctrl[2].bank_discard), 32'h1);
        while (ctrl[2].bank_discard === 1'b1 && t < 40)
        begin
            @(posedge clk_i);
            t++;
        end
        chk("discard time", 32'(t), 32'(d) + 32'h2);
        $display("test kill done");
    endtask
    task automatic t_desc;
        wb(1'b1, 12'h310, 4'hf, 32'h1234_567f);
        wb(1'b1, 12'h310, 4'h8, 32'hff00_0000);
        wb(1'b0, 12'h310, 4'hf, 32'h0);
        chk("desc wr", rdat, 32'hff34_5670);
        wb(1'b0, 12'h314, 4'hf, 32'h0);
        chk("unmapped", rdat, 32'h0);
        dload[2] <= '{load: 1'b1, addr: 32'habcd_ef1f};
        @(posedge clk_i);
        dload[2].load <= 1'b0;
        @(posedge clk_i);
        chk("desc load", nd[2], 32'habcd_ef10);
        wb(1'b0, 12'h330, 4'hf, 32'h0);
        chk("desc read", rdat, 32'habcd_ef10);
        $display("test desc done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_bits();
        t_mask();
        t_toggle_stall();
        t_kill(4'h0);
        t_kill(4'h9);
        t_desc();
        final_report();
    end
endmodule

bind uecsc_top uecsc_props #(.HB_ISO_PRESENT(HB_ISO_PRESENT)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ep_evt_i(ep_evt_i), .ep_ctrl_o(ep_ctrl_o),
    .desc_load_i(desc_load_i), .next_desc_o(next_desc_o));

`default_nettype wire
